// ### src/pulse_train_width_capture.v
// pulse train width capture with output fifo
// assumes the capture pin is a plain input; start pulses from software logic
`timescale 1ns/10ps
`default_nettype none
`include "pulse_train_width_capture_map.vh"

module width_fifo #(
    parameter WIDTH = 16,
    parameter DEPTH = 32,
    parameter AW    = 5
) (
    // clock and reset
    input  wire             sys_clk,
    input  wire             rst,
    // fill side
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    // drain side
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem [0:DEPTH-1];
    reg [AW-1:0]    wr_q;
    reg [AW-1:0]    rd_q;
    reg [AW:0]      cnt_q;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_q != DEPTH);
    assign out_valid = (cnt_q != 0);
    assign out_data  = mem[rd_q];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge sys_clk) begin
        if (push) begin
            mem[wr_q] <= in_data;
        end
    end

    always @(posedge sys_clk) begin
        if (rst) begin
            wr_q  <= {AW{1'b0}};
            rd_q  <= {AW{1'b0}};
            cnt_q <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_q <= wr_q + 1'b1;
            end
            if (pop) begin
                rd_q <= rd_q + 1'b1;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 1'b1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 1'b1;
            end
        end
    end
endmodule

module pulse_train_width_capture #(
    parameter WIDTH_W    = `PTWC_WIDTH_W,
    parameter COUNT_W    = `PTWC_COUNT_W,
    parameter FIFO_DEPTH = `PTWC_FIFO_DEPTH,
    parameter FIFO_AW    = 5
) (
    // clock and reset
    input  wire               sys_clk,
    input  wire               rst,
    // capture pin, input only
    input  wire               capture_pin,
    // control
    input  wire               start,
    input  wire               start_edge_select,
    input  wire [COUNT_W-1:0] width_count_target,
    output reg                busy_q,
    output reg                done_q,
    // width stream
    output reg                width_valid_q,
    input  wire               width_ready,
    output reg  [WIDTH_W-1:0] width_data_q
);
    localparam ST_IDLE = 2'd0;
    localparam ST_ARM  = 2'd1;
    localparam ST_MEAS = 2'd2;
    localparam ST_WAIT = 2'd3;

    // tick increment, cut on purpose to the accumulator plus carry
    localparam [63:0]               PHASE_INC_FULL = `PTWC_PHASE_INC;
    localparam [`PTWC_PHASE_W:0]    PHASE_INC      = PHASE_INC_FULL[`PTWC_PHASE_W:0];

    reg  [1:0]                state_q;
    reg                       sync1_q;
    reg                       sync2_q;
    reg                       prev_q;
    reg                       edge_q;
    reg  [`PTWC_PHASE_W-1:0]  phase_q;
    reg                       tick_q;
    reg  [WIDTH_W-1:0]        width_q;
    reg  [COUNT_W-1:0]        left_q;
    reg                       push_q;
    reg  [WIDTH_W-1:0]        push_data_q;
    wire                      fifo_in_ready;
    wire                      fifo_out_valid;
    wire [WIDTH_W-1:0]        fifo_out_data;
    wire                      rise;
    wire                      fall;
    wire                      start_hit;
    wire [`PTWC_PHASE_W:0]    phase_sum;

    assign rise      = sync2_q && !prev_q;
    assign fall      = !sync2_q && prev_q;
    assign start_hit = (edge_q == `PTWC_EDGE_RISE) ? rise : fall;
    assign phase_sum = {1'b0, phase_q} + PHASE_INC;

    // synchroniser and edge history
    always @(posedge sys_clk) begin
        if (rst) begin
            sync1_q <= 1'b0;
            sync2_q <= 1'b0;
            prev_q  <= 1'b0;
        end else begin
            sync1_q <= capture_pin;
            sync2_q <= sync1_q;
            prev_q  <= sync2_q;
        end
    end

    // fractional tick divider
    always @(posedge sys_clk) begin
        if (rst || state_q != ST_MEAS || rise || fall) begin
            phase_q <= {`PTWC_PHASE_W{1'b0}};
            tick_q  <= 1'b0;
        end else begin
            phase_q <= phase_sum[`PTWC_PHASE_W-1:0];
            tick_q  <= phase_sum[`PTWC_PHASE_W];
        end
    end

    // capture sequencer
    always @(posedge sys_clk) begin
        if (rst) begin
            state_q     <= ST_IDLE;
            edge_q      <= `PTWC_EDGE_FALL;
            width_q     <= {WIDTH_W{1'b0}};
            left_q      <= {COUNT_W{1'b0}};
            push_q      <= 1'b0;
            push_data_q <= {WIDTH_W{1'b0}};
            busy_q      <= 1'b0;
            done_q      <= 1'b0;
        end else begin
            push_q <= 1'b0;
            done_q <= 1'b0;
            case (state_q)
            ST_IDLE: begin
                if (start && width_count_target != 0) begin
                    edge_q  <= start_edge_select;
                    left_q  <= width_count_target;
                    busy_q  <= 1'b1;
                    state_q <= ST_ARM;
                end
            end
            ST_ARM: begin
                if (start_hit) begin
                    width_q <= {WIDTH_W{1'b0}};
                    state_q <= ST_MEAS;
                end
            end
            ST_MEAS: begin
                if (rise || fall) begin
                    // closing edge stores interval, counter restarts
                    push_q      <= 1'b1;
                    push_data_q <= (width_q == {WIDTH_W{1'b0}}) ?
                                   {{(WIDTH_W-1){1'b0}}, 1'b1} : width_q;
                    width_q     <= {WIDTH_W{1'b0}};
                    left_q      <= left_q - 1'b1;
                    if (left_q == {{(COUNT_W-1){1'b0}}, 1'b1}) begin
                        state_q <= ST_WAIT;
                    end
                end else if (tick_q && width_q != `PTWC_WIDTH_MAX) begin
                    width_q <= width_q + 1'b1;
                end
            end
            ST_WAIT: begin
                if (!push_q && !fifo_out_valid && !width_valid_q) begin
                    busy_q  <= 1'b0;
                    done_q  <= 1'b1;
                    state_q <= ST_IDLE;
                end
            end
            default: begin
                state_q <= ST_IDLE;
            end
            endcase
        end
    end

    width_fifo #(
        .WIDTH (WIDTH_W),
        .DEPTH (FIFO_DEPTH),
        .AW    (FIFO_AW)
    ) u_fifo (
        .sys_clk   (sys_clk),
        .rst       (rst),
        .in_valid  (push_q),
        .in_ready  (fifo_in_ready),
        .in_data   (push_data_q),
        .out_valid (fifo_out_valid),
        .out_ready (!width_valid_q || width_ready),
        .out_data  (fifo_out_data)
    );

    // registered output stage
    always @(posedge sys_clk) begin
        if (rst) begin
            width_valid_q <= 1'b0;
            width_data_q  <= {WIDTH_W{1'b0}};
        end else if (!width_valid_q || width_ready) begin
            width_valid_q <= fifo_out_valid;
            width_data_q  <= fifo_out_data;
        end
    end
endmodule

`default_nettype wire

// ### src/pulse_train_width_capture_map.vh
// constants for the pulse train width capture block
// assumes a 125 MHz system clock
// What this block does
// - widths counted in ticks of 1/7372800 second
// - each width is a 16-bit unsigned value, 1 to 65535
// - start edge select 0 arms on falling, 1 on rising
// - nothing recorded before start edge; wait forever for it
// - widths beyond counter range stored as 65535
// - high and low widths stored in order after start edge
// - exactly the requested number of widths measured, then stop; a width that finds the fifo full is dropped
// - done signalled only after the last width is measured and the fifo and output stage have drained
// - capture input is input only, never driven
`ifndef PULSE_TRAIN_WIDTH_CAPTURE_MAP_VH
`define PULSE_TRAIN_WIDTH_CAPTURE_MAP_VH
`define PTWC_CLK_HZ        125000000
`define PTWC_TICK_HZ       7372800
`define PTWC_PHASE_W       32
// phase increment = 2^32 * tick / clk
`define PTWC_PHASE_INC     ((64'd7372800 << 32) / 64'd125000000)
`define PTWC_WIDTH_W       16
`define PTWC_WIDTH_MAX     16'hffff
`define PTWC_COUNT_W       16
`define PTWC_FIFO_DEPTH    32
`define PTWC_EDGE_FALL     1'b0
`define PTWC_EDGE_RISE     1'b1
`endif

// ### tb/pulse_source.sv
// pulse source model driving the capture pin
// assumes the bench calls level() with a level and a hold in ns
`timescale 1ns/10ps
`default_nettype none
module pulse_source (
    // pin
    output var logic pin
);
    initial pin = 1'b0;
    task automatic level(input logic lvl, input int ns);
        pin = lvl;
        #(ns);
    endtask
endmodule
`default_nettype wire

// ### tb/pulse_train_width_capture_asserts.sv
// port checker for the width capture block
// assumes a bind to pulse_train_width_capture
`timescale 1ns/10ps
`default_nettype none
module pulse_train_width_capture_asserts (
    // clock and reset
    input wire logic        sys_clk,
    input wire logic        rst,
    // control and stream
    input wire logic        start,
    input wire logic [15:0] width_count_target,
    input wire logic        busy_q,
    input wire logic        done_q,
    input wire logic        width_valid_q,
    input wire logic        width_ready,
    input wire logic [15:0] width_data_q
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    a_busy_on_start: assert property (
        start && !busy_q && width_count_target != 16'h0 |=> busy_q)
        else $error("no busy after start");
    a_idle_holds: assert property (
        !busy_q && !(start && width_count_target != 16'h0) |=> !busy_q)
        else $error("busy without start");
    a_done_one_cycle: assert property (
        done_q |=> !done_q)
        else $error("done too long");
    a_done_ends_busy: assert property (
        done_q |-> !busy_q && $past(busy_q))
        else $error("done not closing busy");
    a_idle_no_width: assert property (
        !busy_q |-> !width_valid_q)
        else $error("width while idle");
    a_arm_quiet: assert property (
        $rose(busy_q) |-> (!width_valid_q) [*4])
        else $error("width before edge");
    a_width_held: assert property (
        width_valid_q && !width_ready |=> width_valid_q && $stable(width_data_q))
        else $error("width dropped");
    a_width_range: assert property (
        width_valid_q |-> width_data_q != 16'h0)
        else $error("width zero");
    c_done: cover property (done_q);
    c_stall: cover property (width_valid_q && !width_ready);
    c_refuse: cover property (start && width_count_target == 16'h0);
endmodule
`default_nettype wire

// ### tb/pulse_train_width_capture_tb.sv
// bench for the width capture block
// assumes the source model and checker compile first
`timescale 1ns/10ps
`default_nettype none
module pulse_train_width_capture_tb;
    logic        sys_clk = 1'b0;
    logic        rst = 1'b1;
    logic        start = 1'b0;
    logic        start_edge_select = 1'b0;
    logic [15:0] width_count_target = 16'h0;
    logic        width_ready = 1'b1;
    wire logic   capture_pin, busy_q, done_q, width_valid_q;
    wire logic [15:0] width_data_q;
    logic [15:0] got[$];
    int          failures = 0;
    int          checks_done = 0;
    int          dones = 0;
    int          mark = 0;
    pulse_source u_pulse_source (.pin(capture_pin));
    pulse_train_width_capture u_pulse_train_width_capture (.sys_clk(sys_clk), .rst(rst),
        .capture_pin(capture_pin), .start(start), .start_edge_select(start_edge_select),
        .width_count_target(width_count_target), .busy_q(busy_q), .done_q(done_q),
        .width_valid_q(width_valid_q), .width_ready(width_ready), .width_data_q(width_data_q));
    initial forever #4 sys_clk = ~sys_clk;
    always @(posedge sys_clk) if (width_valid_q && width_ready) got.push_back(width_data_q);
    always @(posedge sys_clk) if (done_q === 1'b1) dones++;
    task automatic close_out();
        if (failures == 0 && checks_done > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input string what, input longint lo, input longint hi, input logic [15:0] seen);
        logic ok;
        ok = seen >= lo && seen <= hi;
        checks_done++;
        if (ok !== 1'b1) begin
            failures++;
            $display("wrong value %s expected %0d seen %0d", what, lo, seen);
        end
    endtask
    task automatic go(input logic sel, input logic [15:0] n, input logic busy_exp);
        mark = dones;
        @(posedge sys_clk);
        #1 start = 1'b1;
        start_edge_select = sel;
        width_count_target = n;
        @(posedge sys_clk);
        #1 start = 1'b0;
        check("busy", busy_exp, busy_exp, busy_q);
    endtask
    task automatic wait_done();
        int n;
        n = 0;
        while (dones == mark && n < 20000) begin
            @(posedge sys_clk);
            #1 n++;
        end
        check("done", 1, 1, dones - mark);
        check("idle", 0, 0, busy_q);
        if (n == 20000) close_out();
    endtask
    task automatic pop_w(input longint ns);
        longint t;
        t = ns * 7372800 / 1000000000;
        check("width", t - 1, t + 1, got.pop_front());
    endtask
    task automatic run_rising();
        go(1'b1, 16'h0003, 1'b1);
        u_pulse_source.level(1'b0, 2000);
        u_pulse_source.level(1'b1, 13600);
        u_pulse_source.level(1'b0, 27200);
        u_pulse_source.level(1'b1, 40800);
        u_pulse_source.level(1'b0, 1000);
        wait_done();
        check("count", 3, 3, got.size());
        pop_w(13600);
        pop_w(27200);
        pop_w(40800);
    endtask
    task automatic run_falling_stalled();
        width_ready = 1'b0;
        go(1'b0, 16'h0004, 1'b1);
        u_pulse_source.level(1'b1, 5000);
        u_pulse_source.level(1'b0, 13600);
        u_pulse_source.level(1'b1, 27200);
        u_pulse_source.level(1'b0, 13600);
        u_pulse_source.level(1'b1, 27200);
        u_pulse_source.level(1'b0, 13600);
        u_pulse_source.level(1'b1, 8000);
        check("early done", 0, 0, dones - mark);
        check("busy held", 1, 1, busy_q);
        width_ready = 1'b1;
        wait_done();
        check("count", 4, 4, got.size());
        pop_w(13600);
        pop_w(27200);
        pop_w(13600);
        pop_w(27200);
    endtask
    task automatic run_zero_target();
        go(1'b1, 16'h0000, 1'b0);
        u_pulse_source.level(1'b0, 4000);
        u_pulse_source.level(1'b1, 4000);
        check("count", 0, 0, got.size());
    endtask
    initial begin
        repeat (3) @(posedge sys_clk);
        #1 rst = 1'b0;
        run_rising();
        run_falling_stalled();
        run_zero_target();
        close_out();
    end
endmodule
bind pulse_train_width_capture pulse_train_width_capture_asserts u_pulse_train_width_capture_asserts (
    .sys_clk(sys_clk), .rst(rst), .start(start), .width_count_target(width_count_target),
    .busy_q(busy_q), .done_q(done_q), .width_valid_q(width_valid_q),
    .width_ready(width_ready), .width_data_q(width_data_q));
`default_nettype wire
